/* File: bench/didf_monitor.sv */
// checker for the debounce filter top, bound into every didf_top
// assumes one clock domain and the two-flop reset release of the top
`timescale 1ns/1ps
`default_nettype none
module didf_monitor
  import didf_pkg::*;
#(
  parameter bit SERVO_TICK     = 1'b0,
  parameter bit VOLATILE_STORE = 1'b0
)
(
  input wire logic                clk_i,
  input wire logic                rstn_i,
  input wire logic [NUM_RAW-1:0]  raw_i,
  input wire logic                fval_wr_i,
  input wire logic [CH_W-1:0]     fval_ch_i,
  input wire logic [FVAL_W-1:0]   fval_i,
  input wire logic [FVAL_W-1:0]   fval_rd_o,
  input wire logic                reassign_i,
  input wire logic                save_i,
  input wire logic                nv_wr_o,
  input wire logic                wait_start_i,
  input wire logic [CH_W-1:0]     wait_ch_i,
  input wire logic                wait_level_i,
  input wire logic                wait_busy_o,
  input wire logic                wait_done_o,
  input wire logic [NUM_CH-1:0]   state_o,
  input wire logic                tick_o
);
  localparam int PER = SERVO_TICK ? TICK_CYC_SERVO : TICK_CYC_OTHER;
  logic [2:0]  up_r;
  logic [15:0] gap_r;
  logic        seen_r;
  // ******
  // helpers: first tick has arbitrary phase, so period is checked from the second
  // ******
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      up_r <= 3'h0;
      gap_r <= 16'h0000;
      seen_r <= 1'b0;
    end
    else
    begin
      up_r <= (up_r == 3'h7) ? up_r : up_r + 3'h1;
      gap_r <= tick_o ? 16'h0000 : gap_r + 16'h0001;
      seen_r <= seen_r | tick_o;
    end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  tick_width_a: assert property (tick_o |=> !tick_o) else $error("long tick");
  tick_period_a: assert property (tick_o && seen_r |-> gap_r == PER - 1)
    else $error("tick period");
  init_state_a: assert property (up_r == 3'h5 && $stable(raw_i) && !reassign_i
    |-> state_o == raw_i[7:0]) else $error("init state");
  save_pulse_a: assert property (save_i && up_r == 3'h7 |=> nv_wr_o == !VOLATILE_STORE)
    else $error("save pulse");
  write_cause_a: assert property (nv_wr_o |-> $past(save_i)) else $error("stray store");
  done_width_a: assert property (wait_done_o && !wait_start_i |=> !wait_done_o)
    else $error("long done");
  quick_wait_a: assert property (wait_start_i && !wait_busy_o && up_r == 3'h7
    && state_o[wait_ch_i] == wait_level_i |=> wait_done_o) else $error("slow wait");
  read_back_a: assert property (fval_wr_i && up_r == 3'h7 ##1
    (!fval_wr_i && $stable(fval_ch_i))[*3] |-> fval_rd_o == $past(fval_i, 3))
    else $error("read back");
endmodule
bind didf_top didf_monitor #(.SERVO_TICK(SERVO_TICK), .VOLATILE_STORE(VOLATILE_STORE))
  didf_monitor_inst (.clk_i, .rstn_i, .raw_i, .fval_wr_i, .fval_ch_i, .fval_i,
  .fval_rd_o, .reassign_i, .save_i, .nv_wr_o, .wait_start_i, .wait_ch_i,
  .wait_level_i, .wait_busy_o, .wait_done_o, .state_o, .tick_o);
`default_nettype wire

/* File: bench/didf_switch_model.sv */
// bouncing contact model for the raw inputs
// assumes step_i is driven off the falling edge, one pulse per advance
`timescale 1ns/1ps
`default_nettype none
module didf_switch_model
(
  input  wire logic        clk_i,    // clock
  input  wire logic [15:0] level_i,  // settled levels
  input  wire logic [7:0]  bounce_i, // flips after a change
  input  wire logic        step_i,   // advance contacts
  output logic      [15:0] raw_o     // levels at the pins
);
  logic [15:0] lvl_q = 16'h0000;
  logic [15:0] mask = 16'h0000;
  int          n = 0;
  initial raw_o = 16'h0000;
  // contacts move only on a step, so a bounce spans whole sample periods
  always @(posedge clk_i)
  begin
    if (level_i !== lvl_q)
    begin
      mask = level_i ^ lvl_q;
      lvl_q = level_i;
      n = bounce_i;
    end
    if (step_i)
    begin
      if (n > 0)
        n--;
      raw_o <= level_i ^ ((n % 2) ? mask : 16'h0000);
    end
  end
endmodule
`default_nettype wire

/* File: bench/digital_input_debounce_filter_bench.sv */
// self-checking bench for the debounce filter against an integer model
// assumes didf_top with default parameters, clocked at 100 MHz
`timescale 1ns/1ps
`default_nettype none
module digital_input_debounce_filter_bench;
  import didf_pkg::*;
  logic clk_i, rstn_i, fval_wr_i, reassign_i, save_i, step_i, done_seen;
  logic wait_start_i, wait_level_i, nv_wr_o, wait_busy_o, wait_done_o, tick_o;
  logic nv_valid_i, nv_reassign_i, nv_reassign_o;
  logic [FVAL_W*NUM_CH-1:0] nv_fval_i;
  logic [CH_W-1:0]          fval_ch_i, wait_ch_i;
  logic [FVAL_W-1:0]        fval_i, fval_rd_o;
  logic [NUM_RAW-1:0]       raw_i, level_i;
  logic [FVAL_W*NUM_CH-1:0] nv_fval_o;
  logic [NUM_CH-1:0]        state_o, st;
  logic [7:0]               bounce_i;
  logic [31:0]              seed = 32'h0000_8b80, r;
  int                       fails = 0, check_count = 0, fv[NUM_CH], cn[NUM_CH];
  didf_top didf_top_inst (.clk_i, .rstn_i, .raw_i, .fval_wr_i, .fval_ch_i, .fval_i,
    .fval_rd_o, .reassign_i, .save_i, .nv_valid_i, .nv_fval_i,
    .nv_reassign_i, .nv_wr_o, .nv_fval_o, .nv_reassign_o, .wait_start_i,
    .wait_ch_i, .wait_level_i, .wait_busy_o, .wait_done_o, .state_o, .tick_o);
  didf_switch_model didf_switch_model_inst (.clk_i, .level_i, .bounce_i, .step_i,
    .raw_o(raw_i));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    #1_000_000;
    fails++;
    conclude();
  end
  always @(posedge clk_i)
    if (wait_done_o === 1'b1)
      done_seen <= 1'b1;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // unfiltered channels follow the pin of the selected group
  function automatic logic [7:0] exp_state();
    logic [7:0] e;
    for (int k = 0; k < NUM_CH; k++)
      e[k] = (fv[k] == 0) ? (reassign_i ? raw_i[k+8] : raw_i[k]) : st[k];
    return e;
  endfunction
  task automatic chk(input logic [FVAL_W-1:0] seen, input logic [FVAL_W-1:0] exp,
                     input string what);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic poke();
    step_i = 1'b1;
    @(negedge clk_i);
    step_i = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask
  // ******
  // one sample period: model takes the pins seen at the tick edge
  // ******
  task automatic tick_step();
    int  i;
    logic b;
    i = 0;
    while (tick_o !== 1'b1 && i < 12000)
    begin
      @(negedge clk_i);
      i++;
    end
    chk(tick_o, 1'b1, "tick seen");
    for (int k = 0; k < NUM_CH; k++)
    begin
      b = reassign_i ? raw_i[k+8] : raw_i[k];
      cn[k] = b ? ((cn[k] < fv[k]) ? cn[k] + 1 : fv[k]) : ((cn[k] > 0) ? cn[k] - 1 : 0);
      if (cn[k] == fv[k])
        st[k] = 1'b1;
      else if (cn[k] == 0)
        st[k] = 1'b0;
    end
    repeat (50) @(negedge clk_i);
    poke();
    chk(state_o, exp_state(), "filtered state");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    rstn_i = 1'b0;
    fval_wr_i = 1'b0;
    fval_ch_i = '0;
    fval_i = '0;
    reassign_i = 1'b0;
    save_i = 1'b0;
    wait_start_i = 1'b0;
    wait_ch_i = '0;
    wait_level_i = 1'b0;
    step_i = 1'b0;
    bounce_i = 8'h00;
    done_seen = 1'b0;
    nv_valid_i = 1'b0;
    nv_fval_i = '0;
    nv_reassign_i = 1'b0;
    r = rnd();
    level_i = r[15:0];
    repeat (2) @(negedge clk_i);
    poke();
    repeat (14) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (6) @(negedge clk_i);
    chk(state_o, exp_state(), "reset state");
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      level_i = r[15:0];
      reassign_i = r[16];
      poke();
      chk(state_o, exp_state(), "bypass state");
    end
    level_i = '0;
    reassign_i = 1'b0;
    poke();
    $display("test bypass done");
    for (int k = 0; k < NUM_CH; k++)
    begin
      r = rnd();
      fv[k] = (k > 5) ? 0 : 1 + r % 3;
      cn[k] = 0;
      st[k] = 1'b0;
      fval_ch_i = CH_W'(k);
      fval_i = FVAL_W'(fv[k]);
      fval_wr_i = 1'b1;
      @(negedge clk_i);
    end
    fval_wr_i = 1'b0;
    for (int k = NUM_CH - 1; k >= 0; k--)
    begin
      fval_ch_i = CH_W'(k);
      repeat (4) @(negedge clk_i);
      chk(fval_rd_o, FVAL_W'(fv[k]), "read back");
    end
    save_i = 1'b1;
    @(negedge clk_i);
    save_i = 1'b0;
    chk(nv_wr_o, 1'b1, "store pulse");
    for (int k = 0; k < NUM_CH; k++)
      chk(nv_fval_o[FVAL_W*k+:FVAL_W], FVAL_W'(fv[k]), "stored value");
    chk(nv_reassign_o, reassign_i, "stored group");
    // the store keeps what the model wrote, not what the design exported
    for (int k = 0; k < NUM_CH; k++)
      nv_fval_i[FVAL_W*k+:FVAL_W] = FVAL_W'(fv[k]);
    wait_start_i = 1'b1;
    @(negedge clk_i);
    wait_start_i = 1'b0;
    chk(wait_done_o, 1'b1, "wait at once");
    @(negedge clk_i);
    done_seen = 1'b0;
    wait_level_i = 1'b1;
    wait_start_i = 1'b1;
    @(negedge clk_i);
    wait_start_i = 1'b0;
    chk(wait_busy_o, 1'b1, "wait busy");
    $display("test settings done");
    level_i = 16'h00ff;
    repeat (4) tick_step();
    chk(done_seen, 1'b1, "wait ended");
    level_i = '0;
    bounce_i = 8'h03;
    repeat (3) tick_step();
    $display("test filter done");
    // power cycle with a valid stored set selecting the alternate group
    rstn_i = 1'b0;
    nv_valid_i = 1'b1;
    nv_reassign_i = 1'b1;
    reassign_i = 1'b1;
    bounce_i = 8'h00;
    r = rnd();
    level_i = r[15:0];
    poke();
    rstn_i = 1'b1;
    repeat (6) @(negedge clk_i);
    for (int k = 0; k < NUM_CH; k++)
    begin
      cn[k] = raw_i[k+8] ? fv[k] : 0;
      st[k] = raw_i[k+8];
      chk(nv_fval_o[FVAL_W*k+:FVAL_W], FVAL_W'(fv[k]), "restored value");
    end
    chk(nv_reassign_o, 1'b1, "restored group");
    chk(state_o, exp_state(), "restored state");
    $display("test restore done");
    conclude();
  end
endmodule
`default_nettype wire

/* File: rtl/didf_channel.sv */
// one debounce channel: saturating up/down counter against a filter value
// assumes tick_i is a one-cycle enable and raw_i is synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module didf_channel
  import didf_pkg::*;
(
  input  wire logic              clk_i,     // system clock
  input  wire logic              rst_n_i,   // synchronised reset, active low
  input  wire logic              init_i,    // load from raw level
  input  wire logic              tick_i,    // processor-cycle enable
  input  wire logic              raw_i,     // raw input level
  input  wire logic [FVAL_W-1:0] fval_i,    // programmed filter value
  output logic                   state_o,   // filtered state
  output logic                   steady_o   // counter pinned at an end
);

  typedef struct packed {
    logic [FVAL_W-1:0] cnt;
    logic              state;
  } didf_ch_t;

  didf_ch_t st_r;
  didf_ch_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (init_i)
    begin
      st_nxt.cnt   = raw_i ? fval_i : '0;              // [RQ14]
      st_nxt.state = raw_i;
    end
    else if (fval_i == '0)
    begin
      st_nxt.cnt   = '0;
      st_nxt.state = raw_i;                            // [RQ3]
    end
    else if (tick_i)
    begin
      if (st_r.cnt > fval_i)
        st_nxt.cnt = fval_i;                           // [RQ13]
      else if (raw_i && st_r.cnt != fval_i)
        st_nxt.cnt = st_r.cnt + 16'h0001;              // [RQ4] [RQ13]
      else if (!raw_i && st_r.cnt != '0)
        st_nxt.cnt = st_r.cnt - 16'h0001;              // [RQ4] [RQ13]
      if (st_nxt.cnt == fval_i)
        st_nxt.state = 1'b1;                           // [RQ1] [RQ5] [RQ6]
      else if (st_nxt.cnt == '0)
        st_nxt.state = 1'b0;                           // [RQ5] [RQ6] [RQ9]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign state_o  = st_r.state;
  assign steady_o = (st_r.cnt == '0) || (st_r.cnt == fval_i);

endmodule
`default_nettype wire

/* File: rtl/didf_pkg.sv */
// package of constants for the digital input debounce filter
// assumes a single 100 MHz clock domain
package didf_pkg;

  localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
  localparam int unsigned TICK_NS_SERVO    = 125_000;  // 125 us processor cycle
  localparam int unsigned TICK_NS_OTHER    = 100_000;  // 100 us processor cycle
  localparam int unsigned CLK_PERIOD_NS    = 1_000_000_000 / CLK_FREQ_HZ;
  localparam int unsigned TICK_CYC_SERVO   = TICK_NS_SERVO / CLK_PERIOD_NS;
  localparam int unsigned TICK_CYC_OTHER   = TICK_NS_OTHER / CLK_PERIOD_NS;

  localparam int unsigned NUM_CH           = 8;
  localparam int unsigned NUM_RAW          = 16;
  localparam int unsigned CH_W             = 3;
  localparam int unsigned FVAL_W           = 16;
  localparam int unsigned DIV_W            = 14;
  localparam logic [FVAL_W-1:0] FVAL_RST   = 16'h0000;
  localparam logic              REASSIGN_RST = 1'b0;
  localparam int unsigned ALT_BASE         = 8;

endpackage

/* File: rtl/didf_top.sv */
// digital input debounce filter: tick divider, filter value store,
// channel array and wait-for-input-level helper
// assumes raw inputs and host command strobes are synchronous to clk_i
//
// ******************************************************************
// Overview of operation
// RQ1: filtered state changes after steady programmed cycles
// RQ2: tick 125 us or 100 us per build
// RQ3: zero filter value passes raw level through
// RQ4: count up when high, down when low
// RQ5: report change only at threshold
// RQ6: low at zero, high at filter value
// RQ7: filters disabled after factory defaults
// RQ8: wait completes at once if already satisfied
// RQ9: clean edge lags by filter period
// RQ10: per-input value, set and read back
// RQ11: values retained after save, except one series
// RQ12: reassign channels to alternate input group
// RQ13: counter saturates, never wraps
// RQ14: counters start from raw level at reset
// ******************************************************************
`timescale 1ns/1ps
`default_nettype none
module didf_top
  import didf_pkg::*;
#(
  parameter bit SERVO_TICK     = 1'b0,  // 1 selects 125 us tick
  parameter bit VOLATILE_STORE = 1'b0   // 1: save does not retain values
)
(
  input  wire logic              clk_i,          // system clock
  input  wire logic              rstn_i,         // async reset, active low
  input  wire logic [NUM_RAW-1:0] raw_i,         // raw input levels
  input  wire logic              fval_wr_i,      // write filter value strobe
  input  wire logic [CH_W-1:0]   fval_ch_i,      // channel for write/read
  input  wire logic [FVAL_W-1:0] fval_i,         // filter value to write
  output logic      [FVAL_W-1:0] fval_rd_o,      // filter value read back
  input  wire logic              reassign_i,     // alternate input group
  input  wire logic              save_i,         // save parameters strobe
  input  wire logic              nv_valid_i,     // stored set is valid
  input  wire logic [FVAL_W*NUM_CH-1:0] nv_fval_i, // stored filter values
  input  wire logic              nv_reassign_i,  // stored group select
  output logic                   nv_wr_o,        // store write pulse
  output logic [FVAL_W*NUM_CH-1:0] nv_fval_o,    // values to store
  output logic                   nv_reassign_o,  // group select to store
  input  wire logic              wait_start_i,   // start wait for level
  input  wire logic [CH_W-1:0]   wait_ch_i,      // channel to wait on
  input  wire logic              wait_level_i,   // required level
  output logic                   wait_busy_o,    // wait in progress
  output logic                   wait_done_o,    // wait finished pulse
  output logic [NUM_CH-1:0]      state_o,        // filtered states
  output logic                   tick_o          // processor-cycle tick
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {
    DIDF_ST_LOAD,
    DIDF_ST_INIT,
    DIDF_ST_RUN
  } didf_mode_t;

  typedef struct packed {
    didf_mode_t                     mode;
    logic [DIV_W-1:0]               div;
    logic                           tick;
    logic [NUM_CH-1:0][FVAL_W-1:0]  fval;
    logic                           reassign;
    logic                           nv_wr;
    logic                           busy;
    logic                           done;
    logic [CH_W-1:0]                wch;
    logic                           wlvl;
    logic [FVAL_W-1:0]              rd;
  } didf_state_t;

  didf_state_t st_r;
  didf_state_t st_nxt;

  // the divider is shared by all channels so every filter samples in step
  localparam logic [DIV_W-1:0] TICK_LAST =
    DIV_W'((SERVO_TICK ? TICK_CYC_SERVO : TICK_CYC_OTHER) - 1);   // [RQ2]

  logic [NUM_CH-1:0] raw_sel;
  logic [NUM_CH-1:0] filt;
  logic              ch_init;

  // a changing group select re-seeds the counters from the new inputs
  assign ch_init = (st_r.mode == DIDF_ST_INIT);

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      raw_sel[i] = st_r.reassign ? raw_i[ALT_BASE + i] : raw_i[i];  // [RQ12]
    end
  end

  // ****************************************************************
  // channel array
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      didf_channel u_ch (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n),
        .init_i   (ch_init),
        .tick_i   (st_r.tick),
        .raw_i    (raw_sel[g]),
        .fval_i   (st_r.fval[g]),
        .state_o  (filt[g]),
        .steady_o ()
      );
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.tick  = 1'b0;
    st_nxt.nv_wr = 1'b0;
    st_nxt.done  = 1'b0;

    if (st_r.div == TICK_LAST)
    begin
      st_nxt.div  = '0;
      st_nxt.tick = 1'b1;                                          // [RQ2]
    end
    else
      st_nxt.div = st_r.div + 14'h0001;

    case (st_r.mode)
      DIDF_ST_LOAD:
      begin
        // volatile builds ignore the store and keep defaults
        if (nv_valid_i && !VOLATILE_STORE)                         // [RQ11]
        begin
          st_nxt.fval     = nv_fval_i;
          st_nxt.reassign = nv_reassign_i;
        end
        st_nxt.mode = DIDF_ST_INIT;
      end
      DIDF_ST_INIT:
        st_nxt.mode = DIDF_ST_RUN;                                 // [RQ14]
      default:
      begin
        if (fval_wr_i)
          st_nxt.fval[fval_ch_i] = fval_i;                         // [RQ10]
        if (reassign_i != st_r.reassign)
        begin
          st_nxt.reassign = reassign_i;                            // [RQ12]
          st_nxt.mode     = DIDF_ST_INIT;
        end
        if (save_i && !VOLATILE_STORE)
          st_nxt.nv_wr = 1'b1;                                     // [RQ11]
      end
    endcase

    st_nxt.rd = st_r.fval[fval_ch_i];                              // [RQ10]

    if (st_r.busy)
    begin
      if (filt[st_r.wch] == st_r.wlvl)
      begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;                                        // [RQ9]
      end
    end
    else if (wait_start_i && st_r.mode == DIDF_ST_RUN)
    begin
      // a filtered level that already matches needs no further delay
      if (filt[wait_ch_i] == wait_level_i)
        st_nxt.done = 1'b1;                                        // [RQ8]
      else
      begin
        st_nxt.busy = 1'b1;
        st_nxt.wch  = wait_ch_i;
        st_nxt.wlvl = wait_level_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r          <= '0;
      st_r.mode     <= DIDF_ST_LOAD;
      st_r.fval     <= {NUM_CH{FVAL_RST}};                         // [RQ7]
      st_r.reassign <= REASSIGN_RST;
    end
    else
      st_r <= st_nxt;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign fval_rd_o     = st_r.rd;
  assign nv_wr_o       = st_r.nv_wr;
  assign nv_fval_o     = st_r.fval;
  assign nv_reassign_o = st_r.reassign;
  assign wait_busy_o   = st_r.busy;
  assign wait_done_o   = st_r.done;
  assign state_o       = filt;
  assign tick_o        = st_r.tick;

endmodule
`default_nettype wire
